// ==== timer_reload_and_event_source.sv ====
// APB register file, clock prescaler and six reload timers.
// Assumes pready-driven APB master, asynchronous port pins and a synchronous RTC source level.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module timer_reload_and_event_source
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic port_b_pin0,
    input wire logic port_b_pin1,
    input wire logic rtc_source,
    output logic [timer_pkg::NUM_TIMERS-1:0] end_of_count
);
    import timer_pkg::*;

    typedef struct packed {
        logic [NUM_TIMERS-1:0][CNT_W-1:0] reload;
        logic [NUM_TIMERS-1:0][CTL_W-1:0] ctl;
        logic [NUM_TIMERS-1:0][7:0] high_latch;
        logic [7:0] source_select;
        logic [7:0] snap_high;
        logic [31:0] prdata;
        logic slverr;
        logic [PRESCALE_W-1:0] prescale;
        logic rtc_d;
    } regs_state_s;

    regs_state_s s_r;
    regs_state_s s_nxt;
    logic [NUM_TIMERS-1:0][CNT_W-1:0] count;
    logic [NUM_TIMERS-1:0] load_req;
    logic [NUM_DIV-1:0] div_tick;
    logic [IDX_W-1:0] idx;
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd;
    logic rtc_edge;

    assign idx = paddr[ADDR_LSB+IDX_W-1:ADDR_LSB];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign rtc_edge = rtc_source & ~s_r.rtc_d;

    genvar d;
    generate
        for (d = 0; d < NUM_DIV; d++) begin : g_div
            assign div_tick[d] = &s_r.prescale[2*d+1:0];
        end
    endgenerate

    always_comb begin
        s_nxt = s_r;
        hit = 1'b0;
        rd = 32'h0000_0000;
        s_nxt.prescale = s_r.prescale + 8'h01;
        s_nxt.rtc_d = rtc_source;
        for (int t = 0; t < NUM_TIMERS; t++) begin
            if (idx == CTL_IDX[t]) begin
                hit = 1'b1;
                rd = 32'(s_r.ctl[t]);
            end
            if (idx == RELOAD_LOW_IDX[t]) begin
                hit = 1'b1;
                rd = 32'(count[t][7:0]);
            end
            if (idx == RELOAD_HIGH_IDX[t]) begin
                hit = 1'b1;
                rd = 32'(s_r.high_latch[t]);
            end
            // Restart is one-shot; it clears once the load has happened
            if (load_req[t]) begin
                s_nxt.ctl[t][CTL_RESTART_BIT] = 1'b0;
            end
        end
        if (idx == SOURCE_SELECT_IDX) begin
            hit = 1'b1;
            rd = 32'(s_r.source_select);
        end
        if (setup) begin
            s_nxt.prdata = pwrite ? 32'h0000_0000 : rd;
            s_nxt.slverr = ~hit;
            // Snapshot taken with the low byte so both halves come from one count value
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (idx == RELOAD_LOW_IDX[t]) begin
                    s_nxt.snap_high = count[t][15:8];
                end
            end
        end
        if (access && !s_r.slverr) begin
            for (int t = 0; t < NUM_TIMERS; t++) begin
                if (pwrite && idx == CTL_IDX[t]) begin
                    s_nxt.ctl[t] = pwdata[CTL_W-1:0];
                    // A new restart request beats the clear of the previous one
                    s_nxt.ctl[t][CTL_RESTART_BIT] = pwdata[CTL_RESTART_BIT]
                        | (s_r.ctl[t][CTL_RESTART_BIT] & ~load_req[t]);
                end
                if (pwrite && idx == RELOAD_LOW_IDX[t]) begin
                    s_nxt.reload[t][7:0] = pwdata[7:0];
                end
                if (pwrite && idx == RELOAD_HIGH_IDX[t]) begin
                    s_nxt.reload[t][15:8] = pwdata[7:0];
                end
                if (!pwrite && idx == RELOAD_LOW_IDX[t]) begin
                    s_nxt.high_latch[t] = s_r.snap_high;
                end
            end
            if (pwrite && idx == SOURCE_SELECT_IDX) begin
                s_nxt.source_select = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.reload <= {NUM_TIMERS{RELOAD_RESET}};
            s_r.ctl <= {NUM_TIMERS{CTL_RESET}};
            s_r.source_select <= SOURCE_SELECT_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    genvar t;
    generate
        for (t = 0; t < NUM_TIMERS; t++) begin : g_timer
            logic [SRC_W-1:0] src;
            logic pin;
            if (t < NUM_SEL_TIMERS) begin : g_sel
                assign src = s_r.source_select[2*t+1:2*t];
            end else begin : g_fixed
                assign src = SRC_SYSDIV;
            end
            // Even timers watch pin 0, odd timers pin 1
            assign pin = (t % 2 == 0) ? port_b_pin0 : port_b_pin1;
            assign load_req[t] = s_r.ctl[t][CTL_RESTART_BIT];
            timer_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .div_tick(div_tick[s_r.ctl[t][CTL_DIV_LSB+CTL_DIV_W-1:CTL_DIV_LSB]]),
                .rtc_edge(rtc_edge),
                .event_pin(pin),
                .source_sel(src),
                .run_enable(s_r.ctl[t][CTL_RUN_BIT]),
                .continuous(s_r.ctl[t][CTL_CONT_BIT]),
                .load_req(load_req[t]),
                .reload_value(s_r.reload[t]),
                .count(count[t]),
                .end_of_count(end_of_count[t])
            );
        end
    endgenerate

    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = access & s_r.slverr;
endmodule : timer_reload_and_event_source
`default_nettype wire

// ==== timer_pkg.sv ====
// Constants, register indices and control field layout for the six reload timers.
// Assumes a 32-bit APB master and a 200 MHz pclk; every register index is one word.
package timer_pkg;
    localparam int NUM_TIMERS = 6;
    localparam int NUM_SEL_TIMERS = 4;
    localparam int CLK_MHZ = 200;
    localparam int CNT_W = 16;

    // Word index of each register; the byte address is four times the index
    localparam int IDX_W = 10;
    localparam logic [NUM_TIMERS-1:0][IDX_W-1:0] CTL_IDX =
        {10'h08f, 10'h08c, 10'h089, 10'h086, 10'h083, 10'h080};
    localparam logic [NUM_TIMERS-1:0][IDX_W-1:0] RELOAD_LOW_IDX =
        {10'h090, 10'h08d, 10'h08a, 10'h087, 10'h084, 10'h081};
    localparam logic [NUM_TIMERS-1:0][IDX_W-1:0] RELOAD_HIGH_IDX =
        {10'h091, 10'h08e, 10'h08b, 10'h088, 10'h085, 10'h082};
    localparam logic [IDX_W-1:0] SOURCE_SELECT_IDX = 10'h092;
    localparam int ADDR_LSB = 2;

    // Timer control register layout
    localparam int CTL_W = 5;
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_RESTART_BIT = 1;
    localparam int CTL_DIV_LSB = 2;
    localparam int CTL_DIV_W = 2;
    localparam int CTL_CONT_BIT = 4;
    localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;

    localparam logic [CNT_W-1:0] RELOAD_RESET = 16'h0000;
    localparam logic [7:0] SOURCE_SELECT_RESET = 8'h00;

    // Source-select codes; both 10 and 11 pick the port pin
    localparam int SRC_W = 2;
    localparam logic [SRC_W-1:0] SRC_SYSDIV = 2'b00;
    localparam logic [SRC_W-1:0] SRC_RTC = 2'b01;

    // Divider settings 0..3 give divide by 4, 16, 64 and 256
    localparam int NUM_DIV = 4;
    localparam int PRESCALE_W = 8;
endpackage : timer_pkg

// ==== timer_channel.sv ====
// One 16-bit reload down-counter with its source selection and pin event path.
// Assumes the divided-clock tick and the real-time clock edge arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module timer_channel
    import timer_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic div_tick,
    input wire logic rtc_edge,
    input wire logic event_pin,
    input wire logic [timer_pkg::SRC_W-1:0] source_sel,
    input wire logic run_enable,
    input wire logic continuous,
    input wire logic load_req,
    input wire logic [timer_pkg::CNT_W-1:0] reload_value,
    output logic [timer_pkg::CNT_W-1:0] count,
    output logic end_of_count
);
    import timer_pkg::*;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic sync3;
        logic ev1;
        logic ev2;
        logic eoc;
        logic [CNT_W-1:0] count;
    } chan_state_s;

    chan_state_s s_r;
    chan_state_s s_nxt;
    logic tick;

    always_comb begin
        s_nxt = s_r;
        s_nxt.eoc = 1'b0;
        // Pin rises before edge 1; sync at 1 and 2, edge seen at 3, ev2 at 4, count at 5
        s_nxt.sync1 = event_pin;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.sync3 = s_r.sync2;
        s_nxt.ev1 = s_r.sync2 & ~s_r.sync3;
        s_nxt.ev2 = s_r.ev1;
        if (source_sel == SRC_SYSDIV) begin
            tick = div_tick;
        end else if (source_sel == SRC_RTC) begin
            tick = rtc_edge;
        end else begin
            tick = s_r.ev2;
        end
        tick = tick & run_enable;
        if (load_req) begin
            s_nxt.count = reload_value;
        end else if (tick) begin
            if (s_r.count <= 16'h0001) begin
                s_nxt.eoc = continuous | s_r.count[0];
                // Single-pass parks at zero until software restarts it
                s_nxt.count = continuous ? reload_value : 16'h0000;
            end else begin
                s_nxt.count = s_r.count - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign count = s_r.count;
    assign end_of_count = s_r.eoc;
endmodule : timer_channel
`default_nettype wire

// ==== timer_props.sv ====
// Checker on the timer block's APB and end-of-count ports.
// Bound to the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module timer_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] end_of_count
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire bad = paddr[11:2] < 10'h080 || paddr[11:2] > 10'h092;
    sequence s_setup; psel && !penable; endsequence
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_phase; pslverr |-> psel && penable; endproperty
    a_err_phase: assert property (p_err_phase) else $error("stray slverr");
    property p_err_bad; s_setup ##0 bad |=> pslverr && prdata == 32'h0; endproperty
    a_err_bad: assert property (p_err_bad) else $error("unmapped accepted");
    property p_err_good; s_setup ##0 !bad |=> !pslverr; endproperty
    a_err_good: assert property (p_err_good) else $error("mapped refused");
    property p_err_only; pslverr |-> bad; endproperty
    a_err_only: assert property (p_err_only) else $error("slverr on mapped");
    property p_wr_zero; s_setup ##0 pwrite |=> prdata == 32'h0; endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write returned data");
    property p_hold; psel && penable |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("prdata moved");
    property p_eoc; (end_of_count & $past(end_of_count)) == 6'h0; endproperty
    a_eoc: assert property (p_eoc) else $error("eoc too long");
endmodule : timer_props
bind timer_reload_and_event_source timer_props i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .end_of_count(end_of_count));
`default_nettype wire

// ==== timer_reload_and_event_source_tb.sv ====
// Bench for the reload timers: registers, restart, event sources, continuous reload.
// Assumes the zero-wait APB slave and 200 MHz pclk.
`timescale 1ns/1ps
`default_nettype none
module timer_reload_and_event_source_tb;
    import timer_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pin0 = 1'b0, pin1 = 1'b0, rtc = 1'b0, pready, pslverr;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic [5:0] eoc;
    logic [15:0] r;
    logic [32:0] expq[$];
    int n_errors = 0, n_tests = 0, seed = 59920, gap;
    always #2.5 pclk = ~pclk;
    timer_reload_and_event_source i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_b_pin0(pin0), .port_b_pin1(pin1),
        .rtc_source(rtc), .end_of_count(eoc));
    task automatic cmp(input logic [32:0] got, input logic [32:0] e);
        n_tests++;
        if (got !== e) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, e);
        end
    endtask : cmp
    task automatic cmp_gap(input int got, input int e);
        n_tests++;
        if (got != e) begin
            n_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, e);
        end
    endtask : cmp_gap
    // Leaves psel high so a following transfer can start back to back
    task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [9:0] idx, input logic [32:0] e);
        expq.push_back(e);
        apb(1'b0, idx, 32'h0);
    endtask : rd
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask : idle
    always @(posedge pclk) begin
        if ((psel & penable & pready & ~pwrite) === 1'b1) begin
            cmp({pslverr, prdata}, expq.pop_front());
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    // The tests need under 6000 cycles
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(SOURCE_SELECT_IDX, 33'h0);
        rd(10'h093, 33'h1_0000_0000);
        r = 16'($random(seed));
        wr(SOURCE_SELECT_IDX, {24'h0, r[7:0]});
        rd(SOURCE_SELECT_IDX, {25'h0, r[7:0]});
        $display("test registers done");
        for (int t = 0; t < 6; t++) begin
            r = 16'($random(seed));
            wr(RELOAD_LOW_IDX[t], {24'h0, r[7:0]});
            wr(RELOAD_HIGH_IDX[t], {24'h0, r[15:8]});
            rd(RELOAD_LOW_IDX[t], 33'h0);
            wr(CTL_IDX[t], 32'h2);
            idle(1);
            rd(RELOAD_LOW_IDX[t], {25'h0, r[7:0]});
            rd(RELOAD_HIGH_IDX[t], {25'h0, r[15:8]});
            rd(CTL_IDX[t], 33'h0);
        end
        $display("test restart done");
        for (int c = 1; c < 4; c++) for (int t = 0; t < 4; t++) begin
            wr(SOURCE_SELECT_IDX, 32'(c) << (2 * t));
            wr(RELOAD_LOW_IDX[t], 32'h10);
            wr(RELOAD_HIGH_IDX[t], 32'h0);
            // Slowest divider: only an ignored divider lets the count move in time
            wr(CTL_IDX[t], 32'h0f);
            idle(2);
            // Each source rises once per pass, far below half the clock rate
            if (c == 1) rtc <= 1'b1;
            else if (t % 2) pin1 <= 1'b1;
            else pin0 <= 1'b1;
            // An RTC rise counts at the edge that samples it; a pin needs five edges
            repeat (c == 1 ? 0 : 4) @(posedge pclk);
            rd(RELOAD_LOW_IDX[t], 33'h10);
            rd(RELOAD_LOW_IDX[t], 33'h0f);
            wr(CTL_IDX[t], 32'h0);
            rtc <= 1'b0;
            pin0 <= 1'b0;
            pin1 <= 1'b0;
            idle(4);
        end
        $display("test event sources done");
        wr(SOURCE_SELECT_IDX, 32'h0);
        for (int d = 0; d < 6; d++) begin
            wr(RELOAD_LOW_IDX[d], 32'h2);
            wr(RELOAD_HIGH_IDX[d], 32'h0);
            wr(CTL_IDX[d], 32'h13 | ((d % 4) << 2));
            idle(1);
            for (int k = 0; k < 2; k++) begin
                gap = 0;
                do begin
                    @(posedge pclk);
                    gap++;
                end while (eoc[d] !== 1'b1 && gap < 2000);
            end
            cmp_gap(gap, 2 << (2 * (d % 4) + 2));
            wr(CTL_IDX[d], 32'h0);
        end
        // Single pass must park at zero; a reload would never show zero here
        wr(RELOAD_LOW_IDX[0], 32'h3);
        wr(CTL_IDX[0], 32'h3);
        idle(30);
        rd(RELOAD_LOW_IDX[0], 33'h0);
        wr(CTL_IDX[0], 32'h0);
        idle(1);
        $display("test continuous done");
        end_sim();
    end
endmodule : timer_reload_and_event_source_tb
`default_nettype wire
